// ---- src/sgoc_params.svh ----
`ifndef SGOC_PARAMS_SVH
`define SGOC_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SG_CLK_HZ 50000000
`define SG_TICK_MS 1
`define SG_TICK_CYCLES (`SG_CLK_HZ / 1000 * `SG_TICK_MS)
// ----------------------------------------
// sizes
// ----------------------------------------
`define SG_N_CONTACT 2
`define SG_N_PROT 4
`define SG_N_LOGIC 4
`define SG_N_VIN 4
`define SG_N_VOUT 6
`define SG_N_RELAY 4
`define SG_N_ULED 6
`define SG_N_OBJ 8
`define SG_N_CTRL_OBJ 6
`define SG_TMR_W 20
`define SG_SEL_W 4
// ----------------------------------------
// source vector positions
// ----------------------------------------
`define SG_SRC_CONTACT 0
`define SG_SRC_START 2
`define SG_SRC_TRIP 6
`define SG_SRC_LOGIC 10
`define SG_SRC_OPEN 14
`define SG_SRC_CLOSE 20
`define SG_SRC_FAIL 26
`define SG_N_SRC 27
// ----------------------------------------
// destination vector positions
// ----------------------------------------
`define SG_DST_RELAY 0
`define SG_DST_ALARM 4
`define SG_DST_TRIP 5
`define SG_DST_ULED 6
`define SG_DST_FRT 12
`define SG_DST_VOUT 13
`define SG_N_DST 19
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define SG_OFS_OUT_ROW 12'h000
`define SG_OFS_LATCH 12'h080
`define SG_OFS_CTRL 12'h084
`define SG_OFS_CMD 12'h088
`define SG_OFS_STATUS 12'h08c
`define SG_OFS_FAIL_CLR 12'h090
`define SG_OFS_BLK_ROW 12'h100
`define SG_OFS_OBJ_CFG 12'h140
`define SG_OFS_PULSE 12'h180
`define SG_OFS_READY 12'h1c0
`define SG_CTRL_RELEASE 0
`define SG_CTRL_REMOTE 1
`define SG_CTRL_LR_SEL 4
`define SG_CTRL_REL_SEL 8
`define SG_CTRL_VIN 16
`define SG_CFG_OPEN 0
`define SG_CFG_CLOSE 4
`define SG_CFG_READY 8
`define SG_CFG_ROPEN 12
`define SG_CFG_RCLOSE 16
`define SG_CFG_LOPEN 20
`define SG_CFG_LCLOSE 24
`define SG_CMD_CLOSE 3
`define SG_CMD_OP 4
`define SG_OP_CANCEL 2'h0
`define SG_OP_SELECT 2'h1
`define SG_OP_EXECUTE 2'h2
`define SG_OP_DIRECT 2'h3
`define SG_RST_TIME_MS 20'h003e8
`endif

// ---- src/sgoc_pkg.sv ----
`include "sgoc_params.svh"
package sgoc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OPEN = 3'b010,
    ST_CLOSE = 3'b100
  } sgoc_obj_st_t;
  typedef logic [`SG_N_CTRL_OBJ-1:0] sgoc_ctrl_vec_t;
  typedef logic [`SG_TMR_W-1:0] sgoc_tmr_t;
endpackage

// ---- src/sgoc_top.sv ----
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "sgoc_params.svh"
module sgoc_top #(
  parameter int unsigned TICK_CYCLES = `SG_TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [`SG_N_CONTACT-1:0] CONTACT_INPUT,
  input wire logic [`SG_N_PROT-1:0] PROT_START,
  input wire logic [`SG_N_PROT-1:0] PROT_TRIP,
  input wire logic [`SG_N_LOGIC-1:0] LOGIC_OUT,
  input wire logic KEYPAD_RELEASE,
  input wire logic PANEL_LR_TOGGLE,
  input wire sgoc_pkg::sgoc_ctrl_vec_t PANEL_OPEN,
  input wire sgoc_pkg::sgoc_ctrl_vec_t PANEL_CLOSE,
  input wire sgoc_pkg::sgoc_ctrl_vec_t AR_OPEN,
  input wire sgoc_pkg::sgoc_ctrl_vec_t AR_CLOSE,
  output logic [`SG_N_RELAY-1:0] RELAY_OUT,
  output logic LED_ALARM,
  output logic LED_TRIP,
  output logic [`SG_N_ULED-1:0] LED_USER,
  output logic FAULT_RECORDER_TRIGGER,
  output logic [`SG_N_VOUT-1:0] VIRTUAL_OUT,
  output logic [`SG_N_PROT-1:0] STAGE_BLOCK,
  output sgoc_pkg::sgoc_ctrl_vec_t OBJ_OPEN_CMD,
  output sgoc_pkg::sgoc_ctrl_vec_t OBJ_CLOSE_CMD,
  output logic OBJ_FAILED,
  output logic [`SG_N_OBJ-1:0] UNDEF_EVENT,
  output logic REMOTE_MODE
);
  import sgoc_pkg::*;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int NO = `SG_N_OBJ;
  localparam int NC = `SG_N_CTRL_OBJ;

  // ----------------------------------------
  // registers and shared state
  // ----------------------------------------
  logic [`SG_N_SRC-1:0] out_row [`SG_N_DST];
  logic [`SG_N_SRC-1:0] blk_row [`SG_N_PROT];
  logic [31:0] obj_cfg [NO];
  sgoc_tmr_t pulse_lim [NO];
  sgoc_tmr_t rdy_lim [NO];
  logic [`SG_N_DST-1:0] latch_cfg, out_q;
  logic panel_remote, remote_q;
  logic [`SG_SEL_W-1:0] lr_sel, rel_sel;
  logic [`SG_N_VIN-1:0] vin;
  logic [`SG_N_CONTACT-1:0] c_s1, c_s2;
  logic [TW-1:0] tick_cnt;
  logic tick, rel_prev;
  logic sel_valid, sel_close;
  logic [2:0] sel_obj;
  logic [NC-1:0] bus_open, bus_close;
  logic [NO-1:0] fail, fail_set;
  logic [1:0] obj_code [NO];
  logic [NC-1:0] pulse_open, pulse_close;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire wr = PSEL & PENABLE & PWRITE & PREADY;
  wire [4:0] row_i = PADDR[6:2];
  wire [2:0] obj_i = PADDR[4:2];
  wire is_orow = ({PADDR[11:7], 7'h00} == `SG_OFS_OUT_ROW) && (row_i < 5'(`SG_N_DST));
  wire is_blk = ({PADDR[11:5], 5'h00} == `SG_OFS_BLK_ROW) && (obj_i < 3'(`SG_N_PROT));
  wire is_cfg = {PADDR[11:5], 5'h00} == `SG_OFS_OBJ_CFG;
  wire is_pls = {PADDR[11:5], 5'h00} == `SG_OFS_PULSE;
  wire is_rdy = {PADDR[11:5], 5'h00} == `SG_OFS_READY;
  wire is_latch = PADDR == `SG_OFS_LATCH;
  wire is_ctrl = PADDR == `SG_OFS_CTRL;
  wire is_cmd = PADDR == `SG_OFS_CMD;
  wire is_stat = PADDR == `SG_OFS_STATUS;
  wire is_fclr = PADDR == `SG_OFS_FAIL_CLR;
  wire hit = is_orow | is_blk | is_cfg | is_pls | is_rdy | is_latch | is_ctrl | is_cmd | is_stat | is_fclr;
  wire [1:0] cmd_op = PWDATA[`SG_CMD_OP +: 2];
  wire [2:0] cmd_obj = PWDATA[2:0];
  wire cmd_cl = PWDATA[`SG_CMD_CLOSE];
  wire cmd_wr = wr & is_cmd;
  wire do_exec = cmd_wr & (cmd_op == `SG_OP_EXECUTE) & sel_valid & (sel_obj == cmd_obj) & (sel_close == cmd_cl);
  wire do_direct = cmd_wr & (cmd_op == `SG_OP_DIRECT);
  wire [NO-1:0] fail_clr = (wr & is_fclr) ? PWDATA[NO-1:0] : '0;
  wire [15:0] stat_codes;
  wire [31:0] ctrl_rd = {12'h000, vin, 4'h0, rel_sel, lr_sel, 2'h0, panel_remote, 1'b0};
  wire [31:0] stat_rd = {6'h00, sel_valid, remote_q, fail, stat_codes};
  // read mux; unmapped reads zero with pslverr
  wire [31:0] rd_val = is_orow ? 32'(out_row[row_i]) : is_blk ? 32'(blk_row[obj_i[1:0]]) :
                       is_cfg ? obj_cfg[obj_i] : is_pls ? 32'(pulse_lim[obj_i]) :
                       is_rdy ? 32'(rdy_lim[obj_i]) : is_latch ? 32'(latch_cfg) :
                       is_ctrl ? ctrl_rd : is_stat ? stat_rd : 32'h0000_0000;

  // answer in the first access cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & ~hit;
      PRDATA <= setup ? rd_val : 32'h0000_0000;
    end
  end

  // configuration writes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < `SG_N_DST; i++) out_row[i] <= '0;
      for (int i = 0; i < `SG_N_PROT; i++) blk_row[i] <= '0;
      for (int i = 0; i < NO; i++) begin
        obj_cfg[i] <= 32'h0000_0000;
        pulse_lim[i] <= `SG_RST_TIME_MS;
        rdy_lim[i] <= `SG_RST_TIME_MS;
      end
      latch_cfg <= '0;
      lr_sel <= '0;
      rel_sel <= '0;
      vin <= '0;
    end else if (wr) begin
      if (is_orow) out_row[row_i] <= PWDATA[`SG_N_SRC-1:0];
      if (is_blk) blk_row[obj_i[1:0]] <= PWDATA[`SG_N_SRC-1:0];
      if (is_cfg) obj_cfg[obj_i] <= PWDATA;
      if (is_pls) pulse_lim[obj_i] <= PWDATA[`SG_TMR_W-1:0];
      if (is_rdy) rdy_lim[obj_i] <= PWDATA[`SG_TMR_W-1:0];
      if (is_latch) latch_cfg <= PWDATA[`SG_N_DST-1:0];
      if (is_ctrl) begin
        lr_sel <= PWDATA[`SG_CTRL_LR_SEL +: `SG_SEL_W];
        rel_sel <= PWDATA[`SG_CTRL_REL_SEL +: `SG_SEL_W];
        vin <= PWDATA[`SG_CTRL_VIN +: `SG_N_VIN];
      end
    end
  end

  // panel mode bit: bus write or panel toggle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) panel_remote <= 1'b0;
    else if (wr & is_ctrl) panel_remote <= PWDATA[`SG_CTRL_REMOTE];
    else if (PANEL_LR_TOGGLE) panel_remote <= ~panel_remote;
  end

  // bus commands, no authorization step
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sel_valid <= 1'b0;
      sel_close <= 1'b0;
      sel_obj <= 3'h0;
      bus_open <= '0;
      bus_close <= '0;
    end else begin
      bus_open <= '0;
      bus_close <= '0;
      if ((do_exec | do_direct) & (cmd_obj < 3'(NC))) begin
        bus_open[cmd_obj] <= ~cmd_cl;
        bus_close[cmd_obj] <= cmd_cl;
      end
      if (cmd_wr & (cmd_op == `SG_OP_SELECT)) begin
        sel_valid <= 1'b1;
        sel_obj <= cmd_obj;
        sel_close <= cmd_cl;
      end else if (do_exec | (cmd_wr & (cmd_op == `SG_OP_CANCEL))) begin
        sel_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // inputs, tick and mode
  // ----------------------------------------
  // contact inputs synchronised, one ms tick divider
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      c_s1 <= '0;
      c_s2 <= '0;
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      c_s1 <= CONTACT_INPUT;
      c_s2 <= c_s1;
      tick <= tick_cnt == TW'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // selectable pool: 0 none, contacts, virtual inputs, virtual outputs
  wire [15:0] pool = {3'h0, out_q[`SG_DST_VOUT +: `SG_N_VOUT], vin, c_s2, 1'b0};
  wire [`SG_N_SRC-1:0] src = {|fail, pulse_close, pulse_open, LOGIC_OUT, PROT_TRIP, PROT_START, c_s2};
  wire next_remote = (lr_sel == '0) ? panel_remote : pool[lr_sel];
  wire rel_lvl = (rel_sel != '0) & pool[rel_sel];
  wire release_req = (wr & is_ctrl & PWDATA[`SG_CTRL_RELEASE]) | KEYPAD_RELEASE | (rel_lvl & ~rel_prev);

  // ----------------------------------------
  // output and blocking matrices
  // ----------------------------------------
  logic [`SG_N_DST-1:0] drive, next_out;
  logic [`SG_N_PROT-1:0] next_blk;
  for (genvar d = 0; d < `SG_N_DST; d++) begin : g_dst
    assign drive[d] = |(out_row[d] & src);
    assign next_out[d] = drive[d] | (latch_cfg[d] & out_q[d] & ~release_req);
  end
  for (genvar p = 0; p < `SG_N_PROT; p++) begin : g_blk
    assign next_blk[p] = |(blk_row[p] & src);
  end

  // matrix outputs, mode and release edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_q <= '0;
      STAGE_BLOCK <= '0;
      remote_q <= 1'b0;
      rel_prev <= 1'b0;
      OBJ_FAILED <= 1'b0;
    end else begin
      out_q <= next_out;
      STAGE_BLOCK <= next_blk;
      remote_q <= next_remote;
      rel_prev <= rel_lvl;
      OBJ_FAILED <= |(fail | fail_set);
    end
  end

  assign RELAY_OUT = out_q[`SG_DST_RELAY +: `SG_N_RELAY];
  assign LED_ALARM = out_q[`SG_DST_ALARM];
  assign LED_TRIP = out_q[`SG_DST_TRIP];
  assign LED_USER = out_q[`SG_DST_ULED +: `SG_N_ULED];
  assign FAULT_RECORDER_TRIGGER = out_q[`SG_DST_FRT];
  assign VIRTUAL_OUT = out_q[`SG_DST_VOUT +: `SG_N_VOUT];
  assign REMOTE_MODE = remote_q;

  // ----------------------------------------
  // objects
  // ----------------------------------------
  for (genvar o = 0; o < NO; o++) begin : g_obj
    sgoc_obj_st_t st;
    sgoc_tmr_t ctr, rdy_ctr;
    logic rdy_run, ev;
    logic [3:0] prev;
    wire [31:0] cf = obj_cfg[o];
    wire [3:0] lvl = {pool[cf[`SG_CFG_LCLOSE +: 4]], pool[cf[`SG_CFG_LOPEN +: 4]],
                      pool[cf[`SG_CFG_RCLOSE +: 4]], pool[cf[`SG_CFG_ROPEN +: 4]]};
    wire [3:0] rise = lvl & ~prev;
    wire [1:0] code = {pool[cf[`SG_CFG_CLOSE +: 4]], pool[cf[`SG_CFG_OPEN +: 4]]};
    wire is_open = code == 2'b01;
    wire is_closed = code == 2'b10;
    wire undef = ~is_open & ~is_closed;
    wire ro = o >= NC;
    wire has_rdy = cf[`SG_CFG_READY +: 4] != 4'h0;
    wire rdy_lvl = pool[cf[`SG_CFG_READY +: 4]];
    logic req_open, req_close;
    if (o < NC) begin : g_ctl
      // remote pair and bus in remote, local pair and panel in local
      assign req_open = AR_OPEN[o] | (remote_q ? (rise[0] | bus_open[o]) : (rise[2] | PANEL_OPEN[o]));
      assign req_close = AR_CLOSE[o] | (remote_q ? (rise[1] | bus_close[o]) : (rise[3] | PANEL_CLOSE[o]));
      assign pulse_open[o] = st[1];
      assign pulse_close[o] = st[2];
    end else begin : g_ro
      assign req_open = 1'b0;
      assign req_close = 1'b0;
    end
    wire start = (st == ST_IDLE) & (req_open | req_close);
    wire ro_watch = ro & undef & ~fail[o];
    wire pulse_to = (st != ST_IDLE) & tick & (ctr >= pulse_lim[o]) & ~(st[1] ? is_open : is_closed);
    wire ro_to = (st == ST_IDLE) & ro_watch & tick & (ctr >= pulse_lim[o]);
    wire rdy_to = rdy_run & has_rdy & ~rdy_lvl & tick & (rdy_ctr >= rdy_lim[o]);
    assign fail_set[o] = pulse_to | ro_to | rdy_to;
    assign obj_code[o] = code;
    assign stat_codes[2*o +: 2] = code;

    // pulse state machine, open wins a same-cycle clash
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        st <= ST_IDLE;
        ctr <= '0;
      end else begin
        case (st)
          ST_IDLE: begin
            if (start) begin
              st <= req_open ? ST_OPEN : ST_CLOSE;
              ctr <= '0;
            end else if (!ro_watch) ctr <= '0;
            else if (tick && !ro_to) ctr <= ctr + 1'b1;
          end
          ST_OPEN, ST_CLOSE: begin
            if ((st[1] && is_open) || (st[2] && is_closed) || pulse_to) begin
              st <= ST_IDLE;
              ctr <= '0;
            end else if (tick) ctr <= ctr + 1'b1;
          end
          default: st <= ST_IDLE;
        endcase
      end
    end

    // ready supervision, fail flag (set wins) and event pulse
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        rdy_run <= 1'b0;
        rdy_ctr <= '0;
        fail[o] <= 1'b0;
        ev <= 1'b0;
        prev <= '0;
      end else begin
        prev <= lvl;
        ev <= fail_set[o];
        fail[o] <= fail_set[o] | (fail[o] & ~fail_clr[o]);
        if (start) begin
          rdy_run <= has_rdy;
          rdy_ctr <= '0;
        end else if (rdy_run && (rdy_lvl || rdy_to || !has_rdy)) rdy_run <= 1'b0;
        else if (rdy_run && tick) rdy_ctr <= rdy_ctr + 1'b1;
      end
    end
    assign UNDEF_EVENT[o] = ev;
  end
  assign OBJ_OPEN_CMD = pulse_open;
  assign OBJ_CLOSE_CMD = pulse_close;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_nonlatch_follow: assert property (((out_q ^ $past(drive)) & ~$past(latch_cfg)) == '0)
    else $error("non-latched output differs from drive");
  a_latch_hold: assert property (latch_cfg[0] && out_q[0] && !release_req |=> out_q[0])
    else $error("latched output dropped without release");
  a_release_clear: assert property (release_req && !drive[0] |=> !out_q[0])
    else $error("release did not clear output");
  a_block_map: assert property (STAGE_BLOCK == $past(next_blk))
    else $error("stage block does not follow matrix");
  a_pulse_exclusive: assert property ((pulse_open & pulse_close) == '0)
    else $error("open and close pulse together");
  a_pulse_ends: assert property (g_obj[0].st == ST_OPEN && g_obj[0].is_open |=> !pulse_open[0])
    else $error("open pulse outlived reached state");
  a_timeout_fail: assert property (g_obj[0].pulse_to |=> fail[0] && UNDEF_EVENT[0] ##1 !UNDEF_EVENT[0])
    else $error("timeout did not flag failure");
  a_local_no_bus: assert property (!remote_q && bus_close[0] && !AR_CLOSE[0] && !PANEL_CLOSE[0]
    && !g_obj[0].rise[3] |=> !(g_obj[0].st == ST_CLOSE && $past(g_obj[0].st) == ST_IDLE))
    else $error("bus command taken in local mode");
  a_edge_only: assert property ($past(g_obj[0].lvl[0]) && g_obj[0].lvl[0] |-> !g_obj[0].rise[0])
    else $error("level acted as command");
  a_ro_fail: assert property (g_obj[6].ro_to |-> ##1 fail[6] ##1 OBJ_FAILED)
    else $error("status-only timeout not flagged");
  a_apb_ready: assert property (setup |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle");
  c_latch_release: cover property (latch_cfg[0] && out_q[0] && !drive[0] ##1 release_req ##1 !out_q[0]);
  c_open_done: cover property (pulse_open[0] ##[1:50] !pulse_open[0] && !fail[0]);
  c_select_exec: cover property (sel_valid ##[1:20] do_exec);
  c_fail: cover property (OBJ_FAILED);
endmodule
`default_nettype wire

// ---- tb/sgoc_breaker_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// switching device seen through two auxiliary contacts
// ----------------------------------------
module sgoc_breaker_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic stuck,
  input wire logic [7:0] travel,
  output logic open_fb,
  output logic closed_fb
);
  logic is_closed;
  logic moving;
  logic [7:0] cnt;
  // mechanism starts on a command, moves for travel plus one cycles; a stuck device never starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      is_closed <= 1'b0;
      moving <= 1'b0;
      cnt <= 8'h00;
    end else if (!moving && !stuck && ((open_cmd && is_closed) || (close_cmd && !is_closed))) begin
      moving <= 1'b1;
      cnt <= travel;
    end else if (moving && cnt == 8'h00) begin
      moving <= 1'b0;
      is_closed <= !is_closed;
    end else if (moving) begin
      cnt <= cnt - 8'h01;
    end
  end
  // both contacts open while the main contacts travel, so the code reads undefined
  assign open_fb = !moving && !is_closed;
  assign closed_fb = !moving && is_closed;
endmodule
`default_nettype wire

// ---- tb/switchgear_object_control_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sgoc_params.svh"
module switchgear_object_control_bench;
  import sgoc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int TC = 4;
  localparam int DST[5] = '{4, 5, 6, 12, 13};
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rdata;
  logic PREADY, PSLVERR, rerr, LED_ALARM, LED_TRIP, FRT, OBJ_FAILED, REMOTE_MODE;
  logic [3:0] PROT_START = 0, PROT_TRIP = 0, LOGIC_OUT = 0, RELAY_OUT, STAGE_BLOCK;
  logic KEYPAD_RELEASE = 0, PANEL_LR_TOGGLE = 0, stuck = 0;
  logic [7:0] travel = 8'h06, UNDEF_EVENT;
  logic [5:0] LED_USER, VIRTUAL_OUT;
  sgoc_ctrl_vec_t PANEL_OPEN = 0, PANEL_CLOSE = 0, AR_OPEN = 0, AR_CLOSE = 0, OBJ_OPEN_CMD, OBJ_CLOSE_CMD;
  wire logic open_fb, closed_fb;
  int n_mismatch = 0, tests_run = 0;
  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  always #10 CLK = ~CLK;
  sgoc_top #(.TICK_CYCLES(TC)) uut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONTACT_INPUT({closed_fb, open_fb}), .PROT_START(PROT_START), .PROT_TRIP(PROT_TRIP),
    .LOGIC_OUT(LOGIC_OUT), .KEYPAD_RELEASE(KEYPAD_RELEASE), .PANEL_LR_TOGGLE(PANEL_LR_TOGGLE),
    .PANEL_OPEN(PANEL_OPEN), .PANEL_CLOSE(PANEL_CLOSE), .AR_OPEN(AR_OPEN), .AR_CLOSE(AR_CLOSE),
    .RELAY_OUT(RELAY_OUT), .LED_ALARM(LED_ALARM), .LED_TRIP(LED_TRIP), .LED_USER(LED_USER),
    .FAULT_RECORDER_TRIGGER(FRT), .VIRTUAL_OUT(VIRTUAL_OUT), .STAGE_BLOCK(STAGE_BLOCK),
    .OBJ_OPEN_CMD(OBJ_OPEN_CMD), .OBJ_CLOSE_CMD(OBJ_CLOSE_CMD), .OBJ_FAILED(OBJ_FAILED),
    .UNDEF_EVENT(UNDEF_EVENT), .REMOTE_MODE(REMOTE_MODE));
  sgoc_breaker_model brk (.clk(CLK), .rst(RST), .open_cmd(OBJ_OPEN_CMD[0]), .close_cmd(OBJ_CLOSE_CMD[0]),
    .stuck(stuck), .travel(travel), .open_fb(open_fb), .closed_fb(closed_fb));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    // pready, read data and error are taken at the rising edge that ends the access
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(PREADY));
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // counts command rises of the six controllable objects and failure events of one object over a window
  task automatic obj_chk(input int ncyc, input int ub, input int eo, input int ec, input int eu);
    sgoc_ctrl_vec_t po, pc;
    int o, c, u;
    o = 0;
    c = 0;
    u = 0;
    // every window starts idle, so a pulse already up at the first look counts as new
    po = '0;
    pc = '0;
    repeat (ncyc) begin
      @(negedge CLK);
      o += $countones(OBJ_OPEN_CMD & ~po);
      c += $countones(OBJ_CLOSE_CMD & ~pc);
      u += int'(UNDEF_EVENT[ub] === 1'b1);
      po = OBJ_OPEN_CMD;
      pc = OBJ_CLOSE_CMD;
    end
    chk("open pulses", 32'(eo), 32'(o));
    chk("close pulses", 32'(ec), 32'(c));
    chk("undef events", 32'(eu), 32'(u));
    chk("cmds idle", 32'h0, 32'({OBJ_OPEN_CMD, OBJ_CLOSE_CMD}));
  endtask
  // ----------------------------------------
  // watchdog and tests
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge CLK);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, 12'h07c, 32'h0);
    chk("unmapped error", 32'h1, 32'(rerr));
    chk("unmapped read", 32'h0, rdata);
    wr(`SG_OFS_OUT_ROW, 32'h40);
    for (int i = 0; i < 5; i++) wr(`SG_OFS_OUT_ROW + 12'(4 * DST[i]), 32'h400);
    for (int v = 1; v >= 0; v--) begin
      cyc(1);
      PROT_TRIP <= 4'(v);
      LOGIC_OUT <= 4'(v);
      cyc(3);
      @(negedge CLK);
      chk("matrix outputs", v ? 32'h3f : 32'h0, 32'({RELAY_OUT, LED_ALARM, LED_TRIP, LED_USER[0], FRT, VIRTUAL_OUT[0]}));
    end
    // latch relay 0, release by bus, keypad and selected input
    wr(`SG_OFS_LATCH, 32'h1);
    wr(`SG_OFS_CTRL, 32'h300);
    for (int k = 0; k < 3; k++) begin
      cyc(1);
      PROT_TRIP <= 4'h1;
      cyc(1);
      PROT_TRIP <= 4'h0;
      cyc(3);
      @(negedge CLK);
      chk("latched relay", 32'h1, 32'(RELAY_OUT[0]));
      if (k == 0) wr(`SG_OFS_CTRL, 32'h301);
      else if (k == 2) wr(`SG_OFS_CTRL, 32'h10300);
      else begin
        cyc(1);
        KEYPAD_RELEASE <= 1'b1;
        cyc(1);
        KEYPAD_RELEASE <= 1'b0;
      end
      cyc(3);
      @(negedge CLK);
      chk("latch released", 32'h0, 32'(RELAY_OUT[0]));
    end
    wr(`SG_OFS_CTRL, 32'h0);
    // blocking rows: start 0, contact 0, logic 0
    wr(`SG_OFS_BLK_ROW, 32'h4);
    wr(`SG_OFS_BLK_ROW + 12'h4, 32'h1);
    wr(`SG_OFS_BLK_ROW + 12'h8, 32'h400);
    cyc(1);
    PROT_START <= 4'h1;
    cyc(3);
    @(negedge CLK);
    chk("stage block", 32'h3, 32'(STAGE_BLOCK));
    cyc(1);
    PROT_START <= 4'h0;
    LOGIC_OUT <= 4'h1;
    cyc(3);
    @(negedge CLK);
    chk("stage block", 32'h6, 32'(STAGE_BLOCK));
    // object 0 on contacts, remote close on vin2, local open on vin3
    wr(`SG_OFS_OBJ_CFG, 32'h00650021);
    apb(1'b0, `SG_OFS_STATUS, 32'h0);
    chk("obj0 code", 32'h1, 32'(rdata[1:0]));
    wr(`SG_OFS_CMD, 32'h38);
    obj_chk(40, 0, 0, 0, 0);
    cyc(1);
    PANEL_CLOSE <= 6'h01;
    cyc(1);
    PANEL_CLOSE <= 6'h00;
    obj_chk(60, 0, 0, 1, 0);
    apb(1'b0, `SG_OFS_STATUS, 32'h0);
    chk("obj0 code", 32'h2, 32'(rdata[1:0]));
    wr(`SG_OFS_CTRL, 32'h2);
    cyc(2);
    @(negedge CLK);
    chk("remote mode", 32'h1, 32'(REMOTE_MODE));
    cyc(1);
    PANEL_OPEN <= 6'h01;
    travel <= 8'h14;
    cyc(1);
    PANEL_OPEN <= 6'h00;
    obj_chk(40, 0, 0, 0, 0);
    // a cancelled selection makes the following execute do nothing
    wr(`SG_OFS_CMD, 32'h10);
    wr(`SG_OFS_CMD, 32'h0);
    wr(`SG_OFS_CMD, 32'h20);
    obj_chk(20, 0, 0, 0, 0);
    wr(`SG_OFS_CMD, 32'h10);
    apb(1'b0, `SG_OFS_STATUS, 32'h0);
    chk("select valid", 32'h1, 32'(rdata[25]));
    wr(`SG_OFS_CMD, 32'h20);
    obj_chk(80, 0, 1, 0, 0);
    wr(`SG_OFS_CTRL, 32'h40002);
    obj_chk(300, 0, 0, 1, 0);
    wr(`SG_OFS_CTRL, 32'hc0002);
    obj_chk(60, 0, 0, 0, 0);
    wr(`SG_OFS_CTRL, 32'h2);
    // stuck device: pulse limit 3 ms runs out
    stuck <= 1'b1;
    wr(`SG_OFS_PULSE, 32'h3);
    cyc(1);
    AR_OPEN <= 6'h01;
    cyc(1);
    AR_OPEN <= 6'h00;
    obj_chk(60, 0, 1, 0, 1);
    chk("obj failed", 32'h1, 32'(OBJ_FAILED));
    apb(1'b0, `SG_OFS_STATUS, 32'h0);
    chk("obj0 fail bit", 32'h1, 32'(rdata[16]));
    wr(`SG_OFS_FAIL_CLR, 32'h1);
    stuck <= 1'b0;
    apb(1'b0, `SG_OFS_STATUS, 32'h0);
    chk("obj0 fail bit", 32'h0, 32'(rdata[16]));
    // ready input on vin3 never comes: 2 ms completion timeout fails the object
    wr(`SG_OFS_PULSE, 32'h64);
    wr(`SG_OFS_READY, 32'h2);
    wr(`SG_OFS_OBJ_CFG, 32'h00650621);
    wr(`SG_OFS_CMD, 32'h30);
    obj_chk(60, 0, 1, 0, 1);
    wr(`SG_OFS_FAIL_CLR, 32'h1);
    // status-only object 6 on vin0 and vin1
    wr(`SG_OFS_CMD, 32'h36);
    obj_chk(40, 0, 0, 0, 0);
    wr(`SG_OFS_OBJ_CFG + 12'h18, 32'h43);
    for (int v = 1; v <= 3; v += 2) begin
      wr(`SG_OFS_CTRL, 32'h2 | (32'(v) << 16));
      apb(1'b0, `SG_OFS_STATUS, 32'h0);
      chk("obj6 code", 32'(v), 32'(rdata[13:12]));
    end
    wr(`SG_OFS_PULSE + 12'h18, 32'h2);
    wr(`SG_OFS_FAIL_CLR, 32'h40);
    obj_chk(40, 6, 0, 0, 1);
    apb(1'b0, `SG_OFS_STATUS, 32'h0);
    chk("obj6 fail bit", 32'h1, 32'(rdata[22]));
    // mode taken from vin1 while the panel bit is clear
    for (int v = 1; v >= 0; v--) begin
      wr(`SG_OFS_CTRL, 32'h40 | (32'(v) << 17));
      cyc(3);
      @(negedge CLK);
      chk("mode from input", 32'(v), 32'(REMOTE_MODE));
    end
    // panel toggle flips the mode when no input is selected
    wr(`SG_OFS_CTRL, 32'h0);
    cyc(1);
    PANEL_LR_TOGGLE <= 1'b1;
    cyc(1);
    PANEL_LR_TOGGLE <= 1'b0;
    cyc(2);
    @(negedge CLK);
    chk("mode from panel", 32'h1, 32'(REMOTE_MODE));
    give_verdict();
  end
endmodule
`default_nettype wire
